// [buck_voltage_preset_select.sv]
// What this block does
// RULE1 - four presets per buck, active one regulated
// RULE2 - source bit picks register or pin selection
// RULE3 - register field indexes preset directly
// RULE4 - ten-bit code split high eight, low two
// RULE5 - high write staged, low write applies code
// RULE6 - volts equal code times 1.2mV over divider
// RULE7 - host fixes pin mode before boot
// RULE8 - mode three: spi plus shared pins
// RULE9 - route field picks shared pin or register
// RULE10 - mode four: two global select pins
// RULE11 - global use field maps pins to preset
// RULE12 - mode five: two pin pairs
// RULE13 - mode six: pair plus two single pins
// RULE14 - mode seven: one pin per buck
// RULE15 - host sets source bit before startup
// RULE16 - powerup and powerdown slew fields
// RULE17 - transition up and down slew fields
// RULE18 - slew rate table indexed by divider
// RULE19 - target ramps toward new code
`timescale 1ns/100ps
`include "preset_defines.svh"
module buck_voltage_preset_select
   import preset_pkg::*;
#(
   parameter int NUM_BUCKS = `NUM_BUCKS
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic code_write,
   input wire logic [1:0] write_buck,
   input wire logic [1:0] write_preset,
   input wire logic write_low,
   input wire logic [7:0] write_data,
   input wire logic [3:0] select_source_bit,
   input wire logic [7:0] preset_select_field,
   input wire logic [7:0] pin_route_field,
   input wire logic [7:0] global_pin_use_field,
   input wire logic [2:0] pin_function_mode,
   input wire logic [1:0] feedback_divider,
   input wire logic [11:0] powerup_slew_field,
   input wire logic [11:0] powerdown_slew_field,
   input wire logic [11:0] transition_up_slew_field,
   input wire logic [11:0] transition_down_slew_field,
   input wire logic [3:0] buck_enable,
   input wire logic [3:0] multi_io_in,
   input wire logic [2:0] general_io_in,
   output logic [39:0] dac_target,
   output logic [7:0] active_preset,
   output logic [3:0] ramp_busy,
   output logic [3:0] pins_as_select
);
   // elaboration-time refusal of an unsupported buck count
   if (NUM_BUCKS != 4) begin
      $error("buck count must be four");
   end

   // two flip-flop synchronisers for pins
   logic [3:0] mio_s1, mio_s2;
   logic [2:0] gio_s1, gio_s2;
   always_ff @(posedge mclk) begin
      if (rst) begin
         mio_s1 <= 4'h0;
         mio_s2 <= 4'h0;
         gio_s1 <= 3'h0;
         gio_s2 <= 3'h0;
      end else if (ce) begin
         mio_s1 <= multi_io_in;
         mio_s2 <= mio_s1;
         gio_s1 <= general_io_in;
         gio_s2 <= gio_s1;
      end
   end

   // per-step period in clocks for a slew code and divider
   function automatic logic [11:0] step_clocks(input logic [2:0] slew, input logic [1:0] div);
      logic [11:0] base;
      base = 12'(((`STEP_NS_BASE + `CLK_NS - 1) / `CLK_NS));
      // RULE18 divider scaled rate
      case (div)
         `DIV_0P8: base = 12'(base + (base >> 2));
         `DIV_0P6: base = 12'(base + (base >> 1) + (base >> 3));
         default: base = base;
      endcase
      return 12'(base << slew);
   endfunction

   // staged high bytes, one per buck and preset
   logic [7:0] staged_high [0:15];
   logic [7:0] next_staged_high [0:15];
   logic [9:0] applied [0:15];
   logic [9:0] next_applied [0:15];
   logic [3:0] waddr;
   assign waddr = {write_buck, write_preset};
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         next_staged_high[i] = staged_high[i];
         next_applied[i] = applied[i];
      end
      if (code_write) begin
         if (!write_low) begin
            // RULE5 high write only staged
            next_staged_high[waddr] = write_data;
         end else begin
            // RULE4 RULE5 combine and apply on low write
            next_applied[waddr] = {staged_high[waddr], write_data[1:0]};
         end
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < 16; i++) begin
            staged_high[i] <= 8'h00;
            applied[i] <= `CODE_RESET;
         end
      end else if (ce) begin
         for (int i = 0; i < 16; i++) begin
            staged_high[i] <= next_staged_high[i];
            applied[i] <= next_applied[i];
         end
      end
   end

   // mirror of applied codes in the store
   preset_mem_if mem ();
   preset_store store_u (
      .mclk(mclk),
      .ce(ce),
      .mem(mem)
   );
   assign mem.we = code_write & write_low;
   assign mem.waddr = waddr;
   assign mem.wdata = {staged_high[waddr], write_data[1:0]};
   assign mem.raddr = 4'h0;

   // preset selection per buck
   logic [7:0] next_active_preset;
   logic [3:0] next_pins_as_select;
   function automatic index_t single_pin(input logic p);
      return p ? 2'h1 : 2'h0;
   endfunction
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         logic [1:0] reg_sel, route, use_f, sel;
         logic pin_sel;
         reg_sel = preset_select_field[2*b +: 2];
         route = pin_route_field[2*b +: 2];
         use_f = global_pin_use_field[2*b +: 2];
         // RULE3 register index
         sel = reg_sel;
         pin_sel = 1'b0;
         // RULE2 source bit chooses pins
         if (select_source_bit[b] == `SRC_PINS) begin
            case (pin_function_mode)
               `PIN_MODE_SPI_SHARED: begin
                  // RULE8 RULE9 shared pins a b c on general io
                  pin_sel = (route != `ROUTE_REGISTER);
                  case (route)
                     `ROUTE_PIN_A: sel = single_pin(gio_s2[0]);
                     `ROUTE_PIN_B: sel = single_pin(gio_s2[1]);
                     `ROUTE_PIN_C: sel = single_pin(gio_s2[2]);
                     default: sel = reg_sel;
                  endcase
               end
               `PIN_MODE_GLOBAL: begin
                  // RULE10 RULE11 pin1 on multi_io_0, pin0 on multi_io_1
                  pin_sel = 1'b1;
                  case (use_f)
                     `GLOBAL_PIN0: sel = {1'b0, mio_s2[1]};
                     `GLOBAL_PIN1: sel = {mio_s2[0], 1'b0};
                     `GLOBAL_BOTH: sel = {mio_s2[0], mio_s2[1]};
                     default: sel = 2'h0;
                  endcase
               end
               `PIN_MODE_TWO_PAIRS: begin
                  // RULE12 pairs for bucks one and two
                  if (b < 2) begin
                     pin_sel = 1'b1;
                     sel = {mio_s2[2*b+1], mio_s2[2*b]};
                  end
               end
               `PIN_MODE_PAIR_SINGLES: begin
                  // RULE13 pair for buck one, singles for two and three
                  if (b == 0) begin
                     pin_sel = 1'b1;
                     sel = {mio_s2[1], mio_s2[0]};
                  end else if (b < 3) begin
                     pin_sel = 1'b1;
                     sel = single_pin(mio_s2[b+1]);
                  end
               end
               `PIN_MODE_ALL_SINGLES: begin
                  // RULE14 one pin per buck
                  pin_sel = 1'b1;
                  sel = single_pin(mio_s2[b]);
               end
               default: sel = reg_sel;
            endcase
         end
         next_active_preset[2*b +: 2] = sel;
         next_pins_as_select[b] = pin_sel;
      end
   end

   // ramp engine per buck
   ramp_state_e state [0:3];
   ramp_state_e next_state [0:3];
   logic [9:0] target [0:3];
   logic [9:0] next_target [0:3];
   logic [11:0] cnt [0:3];
   logic [11:0] next_cnt [0:3];
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         logic [9:0] goal;
         logic [2:0] slew;
         slew = 3'h0;
         // RULE1 goal is the active preset code while the buck is enabled, CODE_RESET while it is disabled
         goal = buck_enable[b] ? applied[{2'(b), next_active_preset[2*b +: 2]}] : `CODE_RESET;
         next_state[b] = state[b];
         next_target[b] = target[b];
         next_cnt[b] = cnt[b];
         // RULE16 RULE17 slew field by phase
         if (!buck_enable[b]) begin
            slew = powerdown_slew_field[3*b +: 3];
         end else if (state[b] == ramp_powerup || target[b] == `CODE_RESET) begin
            slew = powerup_slew_field[3*b +: 3];
         end else if (goal > target[b]) begin
            slew = transition_up_slew_field[3*b +: 3];
         end else begin
            slew = transition_down_slew_field[3*b +: 3];
         end
         case (state[b])
            ramp_idle: begin
               if (goal != target[b]) begin
                  next_cnt[b] = step_clocks(slew, feedback_divider);
                  if (!buck_enable[b]) begin
                     next_state[b] = ramp_powerdown;
                  end else if (target[b] == `CODE_RESET) begin
                     next_state[b] = ramp_powerup;
                  end else begin
                     next_state[b] = ramp_transition;
                  end
               end
            end
            ramp_powerup, ramp_transition, ramp_powerdown: begin
               if (goal == target[b]) begin
                  next_state[b] = ramp_idle;
               end else if (cnt[b] <= 12'h001) begin
                  // RULE19 one code step per period
                  next_target[b] = (goal > target[b]) ? 10'(target[b] + 10'h001) : 10'(target[b] - 10'h001);
                  next_cnt[b] = step_clocks(slew, feedback_divider);
               end else begin
                  next_cnt[b] = 12'(cnt[b] - 12'h001);
               end
            end
            default: next_state[b] = ramp_idle;
         endcase
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int b = 0; b < 4; b++) begin
            state[b] <= ramp_idle;
            target[b] <= `CODE_RESET;
            cnt[b] <= 12'h000;
         end
         active_preset <= 8'h00;
         pins_as_select <= 4'h0;
         dac_target <= 40'h0;
         ramp_busy <= 4'h0;
      end else if (ce) begin
         for (int b = 0; b < 4; b++) begin
            state[b] <= next_state[b];
            target[b] <= next_target[b];
            cnt[b] <= next_cnt[b];
            // RULE6 code drives dac, volts scale by divider
            dac_target[10*b +: 10] <= next_target[b];
            ramp_busy[b] <= (next_state[b] != ramp_idle);
         end
         active_preset <= next_active_preset;
         pins_as_select <= next_pins_as_select;
      end
   end

   a_low_write_applies: assert property (@(posedge mclk) disable iff (rst) // RULE5
      (ce && code_write && write_low) |=> applied[$past(waddr)] == {$past(staged_high[waddr]), $past(write_data[1:0])})
      else $error("low write did not apply code");
   a_high_write_staged: assert property (@(posedge mclk) disable iff (rst) // RULE5
      (ce && code_write && !write_low) |=> applied[$past(waddr)] == $past(applied[waddr]))
      else $error("high write changed applied code");
   a_ramp_single_step: assert property (@(posedge mclk) disable iff (rst) // RULE19
      ce |=> (dac_target[9:0] == $past(dac_target[9:0]) || dac_target[9:0] == 10'($past(dac_target[9:0]) + 10'h001)
         || dac_target[9:0] == 10'($past(dac_target[9:0]) - 10'h001))) else $error("ramp stepped more than one");
   a_reg_select: assert property (@(posedge mclk) disable iff (rst) // RULE3
      (ce && select_source_bit[0] == `SRC_REGISTER) |=> active_preset[1:0] == $past(preset_select_field[1:0]))
      else $error("register selection wrong");
   a_single_pin_mode: assert property (@(posedge mclk) disable iff (rst) // RULE14
      (ce && select_source_bit[3] && pin_function_mode == `PIN_MODE_ALL_SINGLES) |=>
      active_preset[7:6] == {1'b0, $past(mio_s2[3])}) else $error("single pin select wrong");
   a_global_force: assert property (@(posedge mclk) disable iff (rst) // RULE11
      (ce && select_source_bit[1] && pin_function_mode == `PIN_MODE_GLOBAL && global_pin_use_field[3:2] == 2'h0)
      |=> active_preset[3:2] == 2'h0) else $error("global force zero wrong");
   a_pair_mode: assert property (@(posedge mclk) disable iff (rst) // RULE12
      (ce && select_source_bit[1] && pin_function_mode == `PIN_MODE_TWO_PAIRS) |=>
      active_preset[3:2] == {$past(mio_s2[3]), $past(mio_s2[2])}) else $error("pair select wrong");
   a_route_reg: assert property (@(posedge mclk) disable iff (rst) // RULE9
      (ce && select_source_bit[0] && pin_function_mode == `PIN_MODE_SPI_SHARED && pin_route_field[1:0] == 2'h3)
      |=> active_preset[1:0] == $past(preset_select_field[1:0]) && !pins_as_select[0])
      else $error("route register wrong");
endmodule

// [buck_voltage_preset_select_tb.sv]
`timescale 1ns/100ps
module buck_voltage_preset_select_tb;
   import preset_pkg::*;
   logic mclk, rst, ce, code_write, write_low;
   logic [1:0] write_buck, write_preset, feedback_divider;
   logic [7:0] write_data, preset_select_field, pin_route_field, global_pin_use_field, active_preset;
   logic [3:0] select_source_bit, buck_enable, multi_io_in, ramp_busy, pins_as_select;
   logic [2:0] pin_function_mode, general_io_in;
   logic [11:0] powerup_slew_field, powerdown_slew_field, transition_up_slew_field, transition_down_slew_field;
   logic [39:0] dac_target;
   int fail_count = 0;
   int samples_checked = 0;
   buck_voltage_preset_select u_buck_voltage_preset_select (.mclk, .rst, .ce, .code_write, .write_buck,
      .write_preset, .write_low, .write_data, .select_source_bit, .preset_select_field, .pin_route_field,
      .global_pin_use_field, .pin_function_mode, .feedback_divider, .powerup_slew_field, .powerdown_slew_field,
      .transition_up_slew_field, .transition_down_slew_field, .buck_enable, .multi_io_in, .general_io_in,
      .dac_target, .active_preset, .ramp_busy, .pins_as_select);
   host_model u_host_model (.mclk, .code_write, .write_buck, .write_preset, .write_low, .write_data,
      .multi_io_in, .general_io_in);
   initial begin
      mclk = 1'h0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask
   task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // counts busy cycles of one ramp and checks the span
   task automatic span(input int b, input int lo, input int hi);
      int n;
      n = 0;
      while (ramp_busy[b] !== 1'h0 && n < 4000) begin
         tick(1);
         n++;
      end
      chk("ramp span", 10'h001, {9'h000, n >= lo && n <= hi});
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic t_stage;
      u_host_model.put(2'h0, 2'h0, 1'h0, 8'h02);
      tick(20);
      chk("dac staged", 10'h000, dac_target[9:0]);
      chk("busy staged", 10'h000, {9'h000, ramp_busy[0]});
      u_host_model.put(2'h0, 2'h0, 1'h1, 8'h01);
      tick(3);
      chk("busy ramp", 10'h001, {9'h000, ramp_busy[0]});
      chk("dac mid ramp", 10'h001, {9'h000, dac_target[9:0] < 10'h009});
      span(0, 0, 3999);
      chk("dac applied", 10'h009, dac_target[9:0]);
      $display("stage done");
   endtask
   task automatic t_regsel;
      for (int p = 1; p < 4; p++) u_host_model.write_code(2'h0, 2'(p), 10'h009 + 10'(4 * p));
      for (int s = 3; s >= 0; s--) begin
         preset_select_field = 8'(s);
         tick(2);
         chk("active reg", 10'(s), {2'h0, active_preset});
         span(0, 0, 3999);
         chk("dac preset", 10'h009 + 10'(4 * s), dac_target[9:0]);
      end
      $display("regsel done");
   endtask
   task automatic t_slew;
      transition_up_slew_field = 12'h001;
      preset_select_field = 8'h01;
      tick(3);
      span(0, 94, 132);
      preset_select_field = 8'h00;
      tick(3);
      span(0, 46, 68);
      feedback_divider = 2'h2;
      preset_select_field = 8'h01;
      tick(3);
      span(0, 154, 212);
      feedback_divider = 2'h1;
      preset_select_field = 8'h00;
      tick(3);
      span(0, 60, 84);
      chk("dac div08", 10'h009, dac_target[9:0]);
      feedback_divider = 2'h0;
      $display("slew done");
   endtask
   task automatic t_freeze;
      ce = 1'h0;
      preset_select_field = 8'h03;
      tick(40);
      chk("frozen active", 10'h000, {2'h0, active_preset});
      chk("frozen dac", 10'h009, dac_target[9:0]);
      ce = 1'h1;
      tick(3);
      chk("thawed active", 10'h003, {2'h0, active_preset});
      chk("thawed busy", 10'h001, {9'h000, ramp_busy[0]});
      span(0, 0, 3999);
      chk("thawed dac", 10'h015, dac_target[9:0]);
      $display("freeze done");
   endtask
   task automatic t_power;
      u_host_model.write_code(2'h1, 2'h0, 10'h004);
      powerup_slew_field = 12'h008;
      buck_enable = 4'h3;
      tick(3);
      span(1, 94, 132);
      chk("dac up", 10'h004, dac_target[19:10]);
      buck_enable = 4'h1;
      tick(3);
      span(1, 46, 68);
      chk("dac down", 10'h000, dac_target[19:10]);
      $display("power done");
   endtask
   task automatic cfg(input logic [2:0] md, input logic [7:0] sel);
      rst = 1'h1;
      pin_function_mode = md;
      select_source_bit = 4'hF;
      preset_select_field = sel;
      tick(2);
      rst = 1'h0;
      tick(1);
   endtask
   task automatic t_mode3;
      cfg(3'h3, 8'hAA);
      for (int r = 0; r < 3; r++) begin
         for (int v = 0; v < 2; v++) begin
            pin_route_field = {4{2'(r)}};
            u_host_model.pins(4'h0, v ? 3'(1 << r) : ~3'(1 << r));
            tick(5);
            chk("active shared", {2'h0, {4{1'h0, 1'(v)}}}, {2'h0, active_preset});
            chk("pins shared", 10'h00F, {6'h00, pins_as_select});
         end
      end
      pin_route_field = 8'hFF;
      tick(3);
      chk("active route reg", 10'h0AA, {2'h0, active_preset});
      chk("pins route reg", 10'h000, {6'h00, pins_as_select});
      $display("mode3 done");
   endtask
   task automatic t_mode4;
      logic [1:0] e;
      cfg(3'h4, 8'h00);
      for (int u = 0; u < 4; u++) begin
         for (int p = 0; p < 4; p++) begin
            global_pin_use_field = {4{2'(u)}};
            u_host_model.pins({2'h0, 1'(p), 1'(p >> 1)}, 3'h0);
            tick(5);
            e = (u == 0) ? 2'h0 : (u == 1) ? {1'h0, 1'(p)} : (u == 2) ? {1'(p >> 1), 1'h0} : 2'(p);
            chk("active global", {2'h0, {4{e}}}, {2'h0, active_preset});
            chk("pins global", 10'h00F, {6'h00, pins_as_select});
         end
      end
      $display("mode4 done");
   endtask
   task automatic t_pins;
      logic [3:0] m;
      logic [7:0] e;
      logic [3:0] used;
      cfg(3'h1, 8'hE4);
      u_host_model.pins(4'hF, 3'h7);
      tick(5);
      chk("active fallback", 10'h0E4, {2'h0, active_preset});
      chk("pins fallback", 10'h000, {6'h00, pins_as_select});
      for (int md = 5; md < 8; md++) begin
         cfg(3'(md), 8'hFF);
         for (int i = 0; i < 16; i++) begin
            m = 4'(i);
            u_host_model.pins(m, 3'h0);
            tick(5);
            if (md == 5) e = {4'hF, m};
            else if (md == 6) e = {2'h3, 1'h0, m[3], 1'h0, m[2], m[1:0]};
            else e = {1'h0, m[3], 1'h0, m[2], 1'h0, m[1], 1'h0, m[0]};
            chk("active pins", {2'h0, e}, {2'h0, active_preset});
            used = (md == 5) ? 4'h3 : (md == 6) ? 4'h7 : 4'hF;
            chk("pins used", {6'h00, used}, {6'h00, pins_as_select});
         end
      end
      $display("pins done");
   endtask
   initial begin
      #1000000;
      fail_count++;
      tally_and_finish;
   end
   initial begin
      rst = 1'h1;
      ce = 1'h1;
      select_source_bit = 4'h0;
      preset_select_field = 8'h00;
      pin_route_field = 8'hFF;
      global_pin_use_field = 8'h00;
      pin_function_mode = 3'h0;
      feedback_divider = 2'h0;
      powerup_slew_field = 12'h000;
      powerdown_slew_field = 12'h000;
      transition_up_slew_field = 12'h000;
      transition_down_slew_field = 12'h000;
      buck_enable = 4'h1;
      tick(16);
      rst = 1'h0;
      tick(1);
      t_stage;
      t_regsel;
      t_slew;
      t_freeze;
      t_power;
      t_mode3;
      t_mode4;
      t_pins;
      tally_and_finish;
   end
endmodule

// [host_model.sv]
`timescale 1ns/100ps
module host_model
   import preset_pkg::*;
(
   input wire logic mclk,
   output logic code_write,
   output logic [1:0] write_buck,
   output logic [1:0] write_preset,
   output logic write_low,
   output logic [7:0] write_data,
   output logic [3:0] multi_io_in,
   output logic [2:0] general_io_in
);
   initial begin
      code_write = 1'h0;
      write_buck = 2'h0;
      write_preset = 2'h0;
      write_low = 1'h0;
      write_data = 8'h00;
      multi_io_in = 4'h0;
      general_io_in = 3'h0;
   end
   task automatic put(input logic [1:0] b, input logic [1:0] p, input logic lo, input logic [7:0] d);
      @(posedge mclk);
      #2;
      code_write = 1'h1;
      write_buck = b;
      write_preset = p;
      write_low = lo;
      write_data = d;
      @(posedge mclk);
      #2;
      code_write = 1'h0;
      // released data lanes carry no stale byte
      write_data = ~d;
   endtask
   // high byte first, low bits last
   task automatic write_code(input logic [1:0] b, input logic [1:0] p, input code_t c);
      put(b, p, 1'h0, c[9:2]);
      put(b, p, 1'h1, {6'h00, c[1:0]});
   endtask
   task automatic pins(input logic [3:0] m, input logic [2:0] g);
      @(posedge mclk);
      #2;
      multi_io_in = m;
      general_io_in = g;
   endtask
endmodule

// [preset_defines.svh]
`ifndef PRESET_DEFINES_SVH
`define PRESET_DEFINES_SVH
`define NUM_BUCKS 4
`define NUM_PRESETS 4
`define CODE_WIDTH 10
`define CODE_HIGH_WIDTH 8
`define CODE_LOW_WIDTH 2
`define SRC_REGISTER 1'h0
`define SRC_PINS 1'h1
`define PIN_MODE_SPI_SHARED 3'h3
`define PIN_MODE_GLOBAL 3'h4
`define PIN_MODE_TWO_PAIRS 3'h5
`define PIN_MODE_PAIR_SINGLES 3'h6
`define PIN_MODE_ALL_SINGLES 3'h7
`define ROUTE_PIN_A 2'h0
`define ROUTE_PIN_B 2'h1
`define ROUTE_PIN_C 2'h2
`define ROUTE_REGISTER 2'h3
`define GLOBAL_FORCE0 2'h0
`define GLOBAL_PIN0 2'h1
`define GLOBAL_PIN1 2'h2
`define GLOBAL_BOTH 2'h3
`define DIV_1P0 2'h0
`define DIV_0P8 2'h1
`define DIV_0P6 2'h2
`define STEP_NS_BASE 400
`define CLK_NS 25
`define CODE_RESET 10'h000
`endif

// [preset_mem_if.sv]
`timescale 1ns/100ps
interface preset_mem_if;
   logic we;
   logic [3:0] waddr;
   logic [9:0] wdata;
   logic [3:0] raddr;
   logic [9:0] rdata;
   modport owner (output we, output waddr, output wdata, output raddr, input rdata);
   modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// [preset_pkg.sv]
package preset_pkg;
   typedef logic [9:0] code_t;
   typedef logic [1:0] index_t;
   typedef enum logic [1:0] {
      ramp_idle,
      ramp_powerup,
      ramp_transition,
      ramp_powerdown
   } ramp_state_e;
endpackage

// [preset_store.sv]
`timescale 1ns/100ps
module preset_store (
   input wire logic mclk,
   input wire logic ce,
   preset_mem_if.store mem
);
   logic [9:0] words [0:15];
   logic [9:0] rdata;
   always_ff @(posedge mclk) begin
      if (ce) begin
         if (mem.we) begin
            words[mem.waddr] <= mem.wdata;
         end
         rdata <= words[mem.raddr];
      end
   end
   assign mem.rdata = rdata;
endmodule
